// ==== verilog/pmc_pkg.sv ====
/*
  Package for the power-mode controller: register offsets, field positions, reset values and
  state codes.
  Assumes a plain register port with one-cycle strobes on a single 200 MHz system clock.
*/
package pmc_pkg;
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;  // power_control_register
  localparam logic [7:0] OSC_CTRL_ADDR = 8'hb2;  // internal_oscillator_control_register
  localparam logic [7:0] WAKE_EN_ADDR = 8'hc0;   // Suspend wake-source enables
  localparam logic [7:0] STATUS_ADDR = 8'hc1;    // Current mode, read only
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int SUSPEND_BIT = 5;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
  localparam logic [7:0] WAKE_EN_RESET = 8'h07;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int WAKE_PORT = 0;
  localparam int WAKE_CMP = 1;
  localparam int WAKE_TMR = 2;

  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_IDLE = 2'b01,
    PMC_STOP = 2'b10,
    PMC_SUSPEND = 2'b11
  } pmc_mode_t;
endpackage : pmc_pkg

// ==== verilog/pmc_power_mode_controller.sv ====
/*
  Power-mode controller: Idle, Stop and Suspend entry, CPU and internal oscillator gating,
  wake handling and reset-vector forcing.
  Assumes the core pulses instr_done when the instruction that wrote a mode bit completes,
  and that the reset input already merges pin, watchdog and missing-clock resets.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_power_mode_controller (
  input wire logic sys_clk,            // 200 MHz system clock
  input wire logic sys_rst,            // Merged reset, async active high
  input wire logic [7:0] reg_addr,     // Register address
  input wire logic [7:0] reg_wdata,    // Write data
  input wire logic reg_wr,             // Write strobe
  input wire logic reg_rd,             // Read strobe
  output logic [7:0] reg_rdata,        // Read data, cycle after strobe
  input wire logic instr_done,         // Pulse: current instruction completed
  input wire logic irq_pending,        // Any enabled interrupt asserted
  input wire logic wdt_timeout,        // Watchdog timeout pulse
  input wire logic wake_port_match,    // Port mismatch wake event
  input wire logic wake_cmp_low,       // Comparator low output
  input wire logic wake_timer_ovf,     // Third timer overflow
  output logic cpu_clk_en,             // CPU clock enable
  output logic periph_clk_en,          // Digital peripheral clock enable
  output logic int_osc_en,             // Internal oscillator enable
  output logic mcd_active,             // Missing-clock detector stays on
  output logic wdt_reset_req,          // Internal reset request from watchdog
  output logic [15:0] fetch_addr_load, // Address to load when fetch_load pulses
  output logic fetch_load,             // One-cycle pulse forcing fetch address
  output logic [1:0] mode_out          // Current power mode
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register and mode state

  pmc_pkg::pmc_mode_t mode_reg, mode_next;
  logic [7:0] pwr_ctrl_reg, pwr_ctrl_next;
  logic [7:0] osc_ctrl_reg, osc_ctrl_next;
  logic [2:0] wake_en_reg, wake_en_next;
  logic idle_req_reg, idle_req_next;
  logic stop_req_reg, stop_req_next;
  logic susp_req_reg, susp_req_next;
  logic [7:0] rdata_reg, rdata_next;
  logic vec_pending_reg, vec_pending_next;
  logic wdt_req_reg, wdt_req_next;
  logic [2:0] wake_hits;

  function automatic logic is_wr(input logic [7:0] addr, input logic [7:0] target,
                                 input logic wr);
    is_wr = wr && (addr == target);
  endfunction : is_wr

  assign wake_hits = {wake_timer_ovf, wake_cmp_low, wake_port_match} & wake_en_reg;

  always_comb begin
    mode_next = mode_reg;
    pwr_ctrl_next = pwr_ctrl_reg;
    osc_ctrl_next = osc_ctrl_reg;
    wake_en_next = wake_en_reg;
    idle_req_next = idle_req_reg;
    stop_req_next = stop_req_reg;
    susp_req_next = susp_req_reg;
    vec_pending_next = 1'b0;
    wdt_req_next = 1'b0;
    rdata_next = 8'h00;

    case (mode_reg)
      pmc_pkg::PMC_RUN: begin
        // Enter only after the setting instruction completes; stop has priority
        if (instr_done && stop_req_reg) begin
          mode_next = pmc_pkg::PMC_STOP;
          stop_req_next = 1'b0;
          idle_req_next = 1'b0;
          susp_req_next = 1'b0;
        end else if (instr_done && susp_req_reg) begin
          mode_next = pmc_pkg::PMC_SUSPEND;
          susp_req_next = 1'b0;
          idle_req_next = 1'b0;
        end else if (instr_done && idle_req_reg) begin
          mode_next = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        // Interrupt clears idle bit and resumes; core services it, PC untouched
        if (irq_pending) begin
          mode_next = pmc_pkg::PMC_RUN;
          idle_req_next = 1'b0;
        end
      end
      pmc_pkg::PMC_STOP: begin
        mode_next = pmc_pkg::PMC_STOP;
      end
      pmc_pkg::PMC_SUSPEND: begin
        // Resume in place: no vector load
        if (|wake_hits) begin
          mode_next = pmc_pkg::PMC_RUN;
        end
      end
      default: begin
        mode_next = pmc_pkg::PMC_RUN;
      end
    endcase

    // Register writes last: a set beats a same-cycle clear; mode bits only arm
    if (is_wr(reg_addr, pmc_pkg::PWR_CTRL_ADDR, reg_wr)) begin
      pwr_ctrl_next = {reg_wdata[7:2], 2'b00};
      if (reg_wdata[pmc_pkg::IDLE_BIT]) begin
        idle_req_next = 1'b1;
      end
      if (reg_wdata[pmc_pkg::STOP_BIT]) begin
        stop_req_next = 1'b1;
      end
    end
    if (is_wr(reg_addr, pmc_pkg::OSC_CTRL_ADDR, reg_wr)) begin
      osc_ctrl_next = reg_wdata;
      osc_ctrl_next[pmc_pkg::SUSPEND_BIT] = 1'b0;
      if (reg_wdata[pmc_pkg::SUSPEND_BIT]) begin
        susp_req_next = 1'b1;
      end
    end
    if (is_wr(reg_addr, pmc_pkg::WAKE_EN_ADDR, reg_wr)) begin
      wake_en_next = reg_wdata[2:0];
    end

    // Watchdog timeout becomes an internal reset request in any non-stop mode
    if (wdt_timeout && mode_reg != pmc_pkg::PMC_STOP) begin
      wdt_req_next = 1'b1;
    end

    if (reg_rd) begin
      case (reg_addr)
        pmc_pkg::PWR_CTRL_ADDR: rdata_next = pwr_ctrl_reg;
        pmc_pkg::OSC_CTRL_ADDR: rdata_next = osc_ctrl_reg;
        pmc_pkg::WAKE_EN_ADDR: rdata_next = {5'h00, wake_en_reg};
        pmc_pkg::STATUS_ADDR: rdata_next = {6'h00, mode_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Reset clears all mode state and arms the vector load
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= pmc_pkg::PMC_RUN;
      pwr_ctrl_reg <= pmc_pkg::PWR_CTRL_RESET;
      osc_ctrl_reg <= pmc_pkg::OSC_CTRL_RESET;
      wake_en_reg <= pmc_pkg::WAKE_EN_RESET[2:0];
      idle_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      susp_req_reg <= 1'b0;
      rdata_reg <= 8'h00;
      vec_pending_reg <= 1'b1;
      wdt_req_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      pwr_ctrl_reg <= pwr_ctrl_next;
      osc_ctrl_reg <= osc_ctrl_next;
      wake_en_reg <= wake_en_next;
      idle_req_reg <= idle_req_next;
      stop_req_reg <= stop_req_next;
      susp_req_reg <= susp_req_next;
      rdata_reg <= rdata_next;
      vec_pending_reg <= vec_pending_next;
      wdt_req_reg <= wdt_req_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops except the constant fetch_addr_load

  logic cpu_clk_reg, periph_clk_reg, osc_reg, mcd_reg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_clk_reg <= 1'b1;
      periph_clk_reg <= 1'b1;
      osc_reg <= 1'b1;
      mcd_reg <= 1'b1;
    end else begin
      cpu_clk_reg <= (mode_next == pmc_pkg::PMC_RUN);
      periph_clk_reg <= (mode_next == pmc_pkg::PMC_RUN) ||
                        (mode_next == pmc_pkg::PMC_IDLE);
      osc_reg <= (mode_next == pmc_pkg::PMC_RUN) ||
                 (mode_next == pmc_pkg::PMC_IDLE);
      mcd_reg <= 1'b1;
    end
  end

  // Analog enables other than int_osc_en and mcd_active live outside this block and are never touched here
  assign cpu_clk_en = cpu_clk_reg;
  assign periph_clk_en = periph_clk_reg;
  assign int_osc_en = osc_reg;
  assign mcd_active = mcd_reg;
  assign wdt_reset_req = wdt_req_reg;
  assign fetch_load = vec_pending_reg;
  assign fetch_addr_load = pmc_pkg::RESET_VECTOR;
  assign mode_out = mode_reg;
  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_idle_entry_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_RUN && idle_req_reg && !stop_req_reg && !susp_req_reg
     && !instr_done) |=> mode_reg == pmc_pkg::PMC_RUN)
    else $error("idle entered before instruction completed");

  a_idle_cpu_halt: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(mode_reg == pmc_pkg::PMC_IDLE) |-> !cpu_clk_en && periph_clk_en)
    else $error("cpu clock not halted in idle");

  a_idle_periph_run: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_reg == pmc_pkg::PMC_IDLE |-> periph_clk_en && int_osc_en)
    else $error("peripheral clock stopped in idle");

  a_idle_hold_noirq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_IDLE && !irq_pending) |=> mode_reg == pmc_pkg::PMC_IDLE)
    else $error("idle left without interrupt");

  a_idle_irq_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_IDLE && irq_pending && !reg_wr)
    |=> mode_reg == pmc_pkg::PMC_RUN && !idle_req_reg && cpu_clk_en)
    else $error("interrupt did not end idle");

  a_wake_no_vector: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_reg != pmc_pkg::PMC_RUN |=> !fetch_load)
    else $error("vector forced on wake");

  a_wdt_reset_req: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wdt_timeout && mode_reg == pmc_pkg::PMC_IDLE) |=> wdt_reset_req)
    else $error("watchdog timeout ignored in idle");

  a_stop_gating: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_reg == pmc_pkg::PMC_STOP |-> !cpu_clk_en && !int_osc_en && !periph_clk_en
    && mcd_active)
    else $error("stop gating wrong");

  a_stop_no_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_reg == pmc_pkg::PMC_STOP |=> mode_reg == pmc_pkg::PMC_STOP)
    else $error("stop left without reset");

  a_susp_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_SUSPEND && (|wake_hits))
    |=> mode_reg == pmc_pkg::PMC_RUN && cpu_clk_en && int_osc_en)
    else $error("suspend did not wake");

  a_susp_hold_nowake: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_SUSPEND && !(|wake_hits)) |=> mode_reg == pmc_pkg::PMC_SUSPEND)
    else $error("suspend left without wake");

  a_susp_osc_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_reg == pmc_pkg::PMC_SUSPEND |-> !int_osc_en && !cpu_clk_en)
    else $error("oscillator running in suspend");

  a_pwr_no_suspend: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_RUN && !susp_req_reg && !stop_req_reg && instr_done
     && !reg_wr) |=> mode_reg != pmc_pkg::PMC_SUSPEND)
    else $error("suspend without oscillator bit");

  a_stop_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_RUN && stop_req_reg && instr_done && !reg_wr)
    |=> mode_reg == pmc_pkg::PMC_STOP ##0 !stop_req_reg)
    else $error("stop not entered");

  a_stop_cfg_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_RUN && stop_req_reg && instr_done && !reg_wr)
    |=> $stable(osc_ctrl_reg) && $stable(wake_en_reg) && $stable(pwr_ctrl_reg))
    else $error("stop entry changed settings");

  a_idle_regs_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_reg == pmc_pkg::PMC_IDLE && !reg_wr)
    |=> $stable(pwr_ctrl_reg) && $stable(osc_ctrl_reg) && $stable(wake_en_reg))
    else $error("register changed in idle");

  a_wdt_stop_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wdt_timeout && mode_reg == pmc_pkg::PMC_STOP) |=> !wdt_reset_req)
    else $error("watchdog active in stop");

  a_reset_run: assert property (@(posedge sys_clk)
    $fell(sys_rst) |-> mode_reg == pmc_pkg::PMC_RUN && cpu_clk_en && fetch_load
    && !idle_req_reg && !stop_req_reg && !susp_req_reg)
    else $error("reset did not restore run");

endmodule : pmc_power_mode_controller

`default_nettype wire

// ==== dv/pmc_core_model.sv ====
/*
  Core, interrupt and watchdog model for the power-mode controller.
  Assumes bench commands change right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
  input wire logic cpu_clk_en, // CPU clocked
  input wire logic step,       // Run one instruction
  input wire logic irq_req,    // Raise an enabled interrupt
  input wire logic wdt_en,     // Watchdog enabled
  input wire logic wdt_fire,   // Watchdog count expired
  output logic instr_done,     // Instruction completed
  output logic irq_pending,    // Enabled interrupt asserted
  output logic wdt_timeout     // Watchdog timeout pulse
);
  // Halted CPU completes nothing; steps are whole multi-byte instructions
  assign instr_done = step & cpu_clk_en;
  assign irq_pending = irq_req;
  // Disabled watchdog never times out
  assign wdt_timeout = wdt_en & wdt_fire;
endmodule : pmc_core_model
`default_nettype wire

// ==== dv/tb.sv ====
/*
  Self-checking testbench for the power-mode controller.
  Assumes the design package and the core model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic step = 1'b0;
  logic irq_req = 1'b0;
  logic wdt_en = 1'b0;
  logic wdt_fire = 1'b0;
  logic [2:0] wake = 3'h0;
  logic [7:0] reg_rdata;
  logic [15:0] fetch_addr_load;
  logic [1:0] mode_out;
  logic instr_done, irq_pending, wdt_timeout, cpu_clk_en, periph_clk_en;
  logic int_osc_en, mcd_active, wdt_reset_req, fetch_load;
  int n_errors = 0;
  int checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;

  pmc_core_model u_core (.cpu_clk_en(cpu_clk_en), .step(step), .irq_req(irq_req),
    .wdt_en(wdt_en), .wdt_fire(wdt_fire), .instr_done(instr_done),
    .irq_pending(irq_pending), .wdt_timeout(wdt_timeout));

  pmc_power_mode_controller u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_done(instr_done), .irq_pending(irq_pending),
    .wdt_timeout(wdt_timeout), .wake_port_match(wake[0]), .wake_cmp_low(wake[1]),
    .wake_timer_ovf(wake[2]), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .int_osc_en(int_osc_en), .mcd_active(mcd_active), .wdt_reset_req(wdt_reset_req),
    .fetch_addr_load(fetch_addr_load), .fetch_load(fetch_load), .mode_out(mode_out));

  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h0, exp}, {8'h0, reg_rdata});
  endtask : rd

  task automatic chk_mode(pmc_pkg::pmc_mode_t m, logic [3:0] en);
    chk("mode_out", {14'h0, m}, {14'h0, mode_out});
    chk("enables", {12'h0, en}, {12'h0, cpu_clk_en, periph_clk_en, int_osc_en, mcd_active});
  endtask : chk_mode

  task automatic instr();
    @(posedge sys_clk);
    step <= 1'b1;
    @(posedge sys_clk);
    step <= 1'b0;
    tick(2);
  endtask : instr

  task automatic do_reset();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    tick(1);
    chk("fetch_load", 16'h1, {15'h0, fetch_load});
    chk("fetch_addr_load", pmc_pkg::RESET_VECTOR, fetch_addr_load);
    chk_mode(pmc_pkg::PMC_RUN, 4'hf);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(1);
    chk("fetch_load", 16'h0, {15'h0, fetch_load});
  endtask : do_reset

  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    wr(8'h55, 8'hff);
    rd(pmc_pkg::PWR_CTRL_ADDR, pmc_pkg::PWR_CTRL_RESET);
    rd(pmc_pkg::OSC_CTRL_ADDR, pmc_pkg::OSC_CTRL_RESET);
    rd(pmc_pkg::WAKE_EN_ADDR, pmc_pkg::WAKE_EN_RESET);
    rd(8'h55, 8'h00);
  endtask : t_regs

  task automatic t_idle();
    wr(pmc_pkg::PWR_CTRL_ADDR, 8'hfd);
    instr();
    chk_mode(pmc_pkg::PMC_IDLE, 4'h7);
    rd(pmc_pkg::PWR_CTRL_ADDR, 8'hfc);
    rd(pmc_pkg::STATUS_ADDR, 8'h01);
    @(posedge sys_clk);
    wake <= 3'h7;
    tick(4);
    chk_mode(pmc_pkg::PMC_IDLE, 4'h7);
    @(posedge sys_clk);
    wake <= 3'h0;
    irq_req <= 1'b1;
    tick(3);
    chk_mode(pmc_pkg::PMC_RUN, 4'hf);
    chk("fetch_load", 16'h0, {15'h0, fetch_load});
    @(posedge sys_clk);
    irq_req <= 1'b0;
    instr();
    chk_mode(pmc_pkg::PMC_RUN, 4'hf);
  endtask : t_idle

  task automatic t_wdt();
    wr(pmc_pkg::PWR_CTRL_ADDR, 8'h01);
    instr();
    @(posedge sys_clk);
    wdt_en <= 1'b1;
    wdt_fire <= 1'b1;
    @(posedge sys_clk);
    wdt_fire <= 1'b0;
    #1;
    chk("wdt_reset_req", 16'h1, {15'h0, wdt_reset_req});
    tick(1);
    chk("wdt_reset_req", 16'h0, {15'h0, wdt_reset_req});
    do_reset();
    rd(pmc_pkg::PWR_CTRL_ADDR, 8'h00);
  endtask : t_wdt

  task automatic t_stop();
    wr(pmc_pkg::PWR_CTRL_ADDR, 8'h02);
    instr();
    chk_mode(pmc_pkg::PMC_STOP, 4'h1);
    @(posedge sys_clk);
    irq_req <= 1'b1;
    wake <= 3'h7;
    wdt_fire <= 1'b1;
    @(posedge sys_clk);
    wdt_fire <= 1'b0;
    #1;
    chk("wdt_reset_req", 16'h0, {15'h0, wdt_reset_req});
    tick(4);
    chk_mode(pmc_pkg::PMC_STOP, 4'h1);
    @(posedge sys_clk);
    irq_req <= 1'b0;
    wake <= 3'h0;
    wdt_en <= 1'b0;
    do_reset();
  endtask : t_stop

  task automatic t_suspend();
    for (int i = 0; i < 3; i++) begin
      wr(pmc_pkg::OSC_CTRL_ADDR, 8'h20);
      instr();
      chk_mode(pmc_pkg::PMC_SUSPEND, 4'h1);
      @(posedge sys_clk);
      wake <= 3'(3'h1 << i);
      tick(3);
      chk_mode(pmc_pkg::PMC_RUN, 4'hf);
      chk("fetch_load", 16'h0, {15'h0, fetch_load});
      @(posedge sys_clk);
      wake <= 3'h0;
    end
    rd(pmc_pkg::OSC_CTRL_ADDR, 8'h00);
    wr(pmc_pkg::WAKE_EN_ADDR, 8'h00);
    wr(pmc_pkg::OSC_CTRL_ADDR, 8'h20);
    instr();
    @(posedge sys_clk);
    wake <= 3'h7;
    irq_req <= 1'b1;
    tick(4);
    chk_mode(pmc_pkg::PMC_SUSPEND, 4'h1);
    @(posedge sys_clk);
    wake <= 3'h0;
    irq_req <= 1'b0;
    do_reset();
  endtask : t_suspend

  ////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_regs();
    t_idle();
    t_wdt();
    t_stop();
    t_suspend();
    stop_test();
  end

  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
